// *** src/mrt_consts.svh ***
// register offsets, reset values and field positions of the metering tail bank
`ifndef MRT_CONSTS_SVH
`define MRT_CONSTS_SVH
`define MRT_ADDR_CURRENT_PEAK 16'hE500
`define MRT_ADDR_VOLTAGE_PEAK 16'hE501
`define MRT_ADDR_REACTIVE_NOLOAD 16'hE909
`define MRT_ADDR_APPARENT_NOLOAD 16'hE90A
`define MRT_ADDR_RSV1_LO 16'hE90B
`define MRT_ADDR_RSV1_HI 16'hE9FD
`define MRT_ADDR_PREV_ADDRESS 16'hE9FE
`define MRT_ADDR_PREV_HALFWORD 16'hE9FF
`define MRT_ADDR_SECOND_CONFIG 16'hEA00
`define MRT_ADDR_PREV_KIND 16'hEA01
`define MRT_ADDR_ACTIVE_THR 16'hEA02
`define MRT_ADDR_REACTIVE_THR 16'hEA03
`define MRT_ADDR_APPARENT_THR 16'hEA04
`define MRT_ADDR_RSV2_LO 16'hEA05
`define MRT_ADDR_RSV2_HI 16'hEBFE
`define MRT_ADDR_PIN_CONTROL 16'hEBFF
`define MRT_NOLOAD_RESET 16'h0000
`define MRT_ENERGY_THR_RESET 8'h03
`define MRT_SECOND_CONFIGURATION_RESET 8'h00
`define MRT_PEAK_VALUE_MSB 23
`define MRT_PEAK_PHASE_LSB 24
`define MRT_PEAK_PHASE_MSB 26
`define MRT_PEAK_ZERO_BITS 5'h00
`define MRT_KIND_READ 8'h00
`define MRT_KIND_WRITE 8'h01
`endif

// *** src/mrt_pkg.sv ***
// types shared by the metering tail register bank
package mrt_pkg;
  typedef enum logic [1:0] {
    MRT_SIZE_8 = 2'b00,
    MRT_SIZE_16 = 2'b01,
    MRT_SIZE_32 = 2'b10,
    MRT_SIZE_NONE = 2'b11
  } mrt_size_type;
  typedef enum logic [1:0] {
    MRT_ST_IDLE = 2'b00,
    MRT_ST_WRITE = 2'b01,
    MRT_ST_READ = 2'b10
  } mrt_state_type;
endpackage

// *** src/mrt_peak_hold.sv ***
// one peak capture register: value plus one-hot source phase
`include "mrt_consts.svh"
module mrt_peak_hold
  import mrt_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic load,
  input wire logic [23:0] value,
  input wire logic [2:0] phase,
  output logic [31:0] word
);
  logic [23:0] peak;
  logic [2:0] source;
  logic [23:0] next_peak;
  logic [2:0] next_source;

  // take a new peak when the detector reports one
  always_comb begin
    next_peak = peak;
    next_source = source;
    if (load) begin
      next_peak = value;
      next_source = phase;
    end
  end

  // registered capture, zero after reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      peak <= 24'h00_0000;
      source <= 3'h0;
    end else begin
      peak <= next_peak;
      source <= next_source;
    end
  end

  // top five bits always zero
  assign word = {`MRT_PEAK_ZERO_BITS, source, peak};
endmodule

// *** src/mrt_tail_bank.sv ***
// metering register bank tail: thresholds, access trace, peaks, pin control
// Notes on behaviour
// - reactive no-load threshold, 16 bits, reset zero
// - apparent no-load threshold, 16 bits, reset zero
// - trace address of last good access
// - trace data of last 16-bit transfer
// - trace whether last access read or write
// - active energy threshold resets to three
// - reactive energy threshold resets to three
// - apparent energy threshold resets to three
// - second configuration byte resets to zero
// - special address drives select/stream pin under SPI
// - current peak low 24 bits, reset zero
// - current peak phase flags bits 24-26
// - peak bits 31 to 27 read zero
// - voltage peak low 24 bits, reset zero
// - voltage peak phase flags bits 24-26
`include "mrt_consts.svh"
module mrt_tail_bank
  import mrt_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  input wire logic [15:0] REG_ADDRESS,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  output logic REG_DONE,
  input wire logic SPI_ACTIVE,
  input wire logic CURRENT_PEAK_LOAD,
  input wire logic [23:0] CURRENT_PEAK_VALUE,
  input wire logic [2:0] CURRENT_PEAK_SOURCE_PHASE,
  input wire logic VOLTAGE_PEAK_LOAD,
  input wire logic [23:0] VOLTAGE_PEAK_VALUE,
  input wire logic [2:0] VOLTAGE_PEAK_SOURCE_PHASE,
  output logic [15:0] REACTIVE_NOLOAD_THRESHOLD,
  output logic [15:0] APPARENT_NOLOAD_THRESHOLD,
  output logic [7:0] SECOND_CONFIGURATION,
  output logic [7:0] ACTIVE_ENERGY_THRESHOLD,
  output logic [7:0] REACTIVE_ENERGY_THRESHOLD,
  output logic [7:0] APPARENT_ENERGY_THRESHOLD,
  output logic SELECT_OR_STREAM_ACTIVE_PIN
);
  logic [15:0] reactive_noload;
  logic [15:0] apparent_noload;
  logic [7:0] second_config;
  logic [7:0] active_thr;
  logic [7:0] reactive_thr;
  logic [7:0] apparent_thr;
  logic [15:0] prev_address;
  logic [15:0] prev_halfword;
  logic [7:0] prev_kind;
  logic pin_level;
  logic [31:0] rdata;
  logic done;
  mrt_state_type state;
  logic [15:0] next_reactive_noload;
  logic [15:0] next_apparent_noload;
  logic [7:0] next_second_config;
  logic [7:0] next_active_thr;
  logic [7:0] next_reactive_thr;
  logic [7:0] next_apparent_thr;
  logic [15:0] next_prev_address;
  logic [15:0] next_prev_halfword;
  logic [7:0] next_prev_kind;
  logic next_pin_level;
  logic [31:0] next_rdata;
  logic next_done;
  mrt_state_type next_state;
  logic [31:0] current_word;
  logic [31:0] voltage_word;
  logic [31:0] read_value;
  mrt_size_type size;
  logic take;
  logic [1:0] peak_load;
  logic [1:0][23:0] peak_value;
  logic [1:0][2:0] peak_phase;
  logic [1:0][31:0] peak_word;

  // one capture per peak channel: 0 current, 1 voltage
  assign peak_load = {VOLTAGE_PEAK_LOAD, CURRENT_PEAK_LOAD};
  assign peak_value = {VOLTAGE_PEAK_VALUE, CURRENT_PEAK_VALUE};
  assign peak_phase = {VOLTAGE_PEAK_SOURCE_PHASE,
                       CURRENT_PEAK_SOURCE_PHASE};
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_peak
      mrt_peak_hold hold_u (
        .clock(CLOCK),
        .resetn(RESETN),
        .load(peak_load[ch]),
        .value(peak_value[ch]),
        .phase(peak_phase[ch]),
        .word(peak_word[ch])
      );
    end
  endgenerate

  // per-channel words seen by the read mux
  assign current_word = peak_word[0];
  assign voltage_word = peak_word[1];

  // read mux and width of the addressed register
  always_comb begin
    read_value = 32'h0000_0000;
    size = MRT_SIZE_NONE;
    case (REG_ADDRESS)
      `MRT_ADDR_CURRENT_PEAK: begin
        read_value = current_word;
        size = MRT_SIZE_32;
      end
      `MRT_ADDR_VOLTAGE_PEAK: begin
        read_value = voltage_word;
        size = MRT_SIZE_32;
      end
      `MRT_ADDR_REACTIVE_NOLOAD: begin
        read_value = {16'h0000, reactive_noload};
        size = MRT_SIZE_16;
      end
      `MRT_ADDR_APPARENT_NOLOAD: begin
        read_value = {16'h0000, apparent_noload};
        size = MRT_SIZE_16;
      end
      `MRT_ADDR_PREV_ADDRESS: begin
        read_value = {16'h0000, prev_address};
        size = MRT_SIZE_16;
      end
      `MRT_ADDR_PREV_HALFWORD: begin
        read_value = {16'h0000, prev_halfword};
        size = MRT_SIZE_16;
      end
      `MRT_ADDR_SECOND_CONFIG: begin
        read_value = {24'h00_0000, second_config};
        size = MRT_SIZE_8;
      end
      `MRT_ADDR_PREV_KIND: begin
        read_value = {24'h00_0000, prev_kind};
        size = MRT_SIZE_8;
      end
      `MRT_ADDR_ACTIVE_THR: begin
        read_value = {24'h00_0000, active_thr};
        size = MRT_SIZE_8;
      end
      `MRT_ADDR_REACTIVE_THR: begin
        read_value = {24'h00_0000, reactive_thr};
        size = MRT_SIZE_8;
      end
      `MRT_ADDR_APPARENT_THR: begin
        read_value = {24'h00_0000, apparent_thr};
        size = MRT_SIZE_8;
      end
      `MRT_ADDR_PIN_CONTROL: begin
        read_value = {31'h0000_0000, pin_level};
        size = MRT_SIZE_8;
      end
      default: begin
        read_value = 32'h0000_0000;
        size = MRT_SIZE_NONE;
      end
    endcase
  end

  // a request is taken only while idle; a held strobe counts once
  assign take = state == MRT_ST_IDLE && (REG_WRITE || REG_READ);

  // handshake: answer one cycle after a request is taken
  always_comb begin
    next_state = state;
    next_done = take;
    next_rdata = rdata;
    case (state)
      MRT_ST_IDLE: begin
        if (REG_WRITE) begin
          next_state = MRT_ST_WRITE;
        end else if (REG_READ) begin
          next_state = MRT_ST_READ;
        end
      end
      MRT_ST_WRITE, MRT_ST_READ: begin
        // hold until the host drops its strobe
        if (!REG_WRITE && !REG_READ) begin
          next_state = MRT_ST_IDLE;
        end
      end
      default: next_state = MRT_ST_IDLE;
    endcase
    if (take) begin
      next_rdata = REG_WRITE ? 32'h0000_0000 : read_value;
    end
  end

  // handshake registers, idle after reset
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rdata <= 32'h0000_0000;
      done <= 1'b0;
      state <= MRT_ST_IDLE;
    end else begin
      rdata <= next_rdata;
      done <= next_done;
      state <= next_state;
    end
  end

  // writable settings; other addresses leave them alone
  always_comb begin
    next_reactive_noload = reactive_noload;
    next_apparent_noload = apparent_noload;
    next_second_config = second_config;
    next_active_thr = active_thr;
    next_reactive_thr = reactive_thr;
    next_apparent_thr = apparent_thr;
    next_pin_level = pin_level;
    if (take && REG_WRITE) begin
      case (REG_ADDRESS)
        `MRT_ADDR_REACTIVE_NOLOAD:
          next_reactive_noload = REG_WDATA[15:0];
        `MRT_ADDR_APPARENT_NOLOAD:
          next_apparent_noload = REG_WDATA[15:0];
        `MRT_ADDR_SECOND_CONFIG:
          next_second_config = REG_WDATA[7:0];
        `MRT_ADDR_ACTIVE_THR:
          next_active_thr = REG_WDATA[7:0];
        `MRT_ADDR_REACTIVE_THR:
          next_reactive_thr = REG_WDATA[7:0];
        `MRT_ADDR_APPARENT_THR:
          next_apparent_thr = REG_WDATA[7:0];
        `MRT_ADDR_PIN_CONTROL: begin
          if (SPI_ACTIVE) begin
            next_pin_level = REG_WDATA[0];
          end
        end
        default: begin
          next_pin_level = pin_level; // read-only, no effect
        end
      endcase
    end
  end

  // settings registers with their reset values
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      reactive_noload <= `MRT_NOLOAD_RESET;
      apparent_noload <= `MRT_NOLOAD_RESET;
      second_config <= `MRT_SECOND_CONFIGURATION_RESET;
      active_thr <= `MRT_ENERGY_THR_RESET;
      reactive_thr <= `MRT_ENERGY_THR_RESET;
      apparent_thr <= `MRT_ENERGY_THR_RESET;
      pin_level <= 1'b1;
    end else begin
      reactive_noload <= next_reactive_noload;
      apparent_noload <= next_apparent_noload;
      second_config <= next_second_config;
      active_thr <= next_active_thr;
      reactive_thr <= next_reactive_thr;
      apparent_thr <= next_apparent_thr;
      pin_level <= next_pin_level;
    end
  end

  // trace of the last access to a mapped register
  always_comb begin
    next_prev_address = prev_address;
    next_prev_halfword = prev_halfword;
    next_prev_kind = prev_kind;
    if (take && size != MRT_SIZE_NONE) begin
      next_prev_address = REG_ADDRESS;
      next_prev_kind = REG_WRITE ? `MRT_KIND_WRITE
                                 : `MRT_KIND_READ;
      if (size == MRT_SIZE_16) begin
        next_prev_halfword = REG_WRITE ? REG_WDATA[15:0]
                                       : read_value[15:0];
      end
    end
  end

  // trace registers, zero after reset
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      prev_address <= 16'h0000;
      prev_halfword <= 16'h0000;
      prev_kind <= 8'h00;
    end else begin
      prev_address <= next_prev_address;
      prev_halfword <= next_prev_halfword;
      prev_kind <= next_prev_kind;
    end
  end

  // outputs straight from flip-flops
  assign REG_RDATA = rdata;
  assign REG_DONE = done;
  assign REACTIVE_NOLOAD_THRESHOLD = reactive_noload;
  assign APPARENT_NOLOAD_THRESHOLD = apparent_noload;
  assign SECOND_CONFIGURATION = second_config;
  assign ACTIVE_ENERGY_THRESHOLD = active_thr;
  assign REACTIVE_ENERGY_THRESHOLD = reactive_thr;
  assign APPARENT_ENERGY_THRESHOLD = apparent_thr;
  assign SELECT_OR_STREAM_ACTIVE_PIN = pin_level;
endmodule

// *** dv/mrt_checker.sv ***
// port-level assertions for the metering tail register bank
module mrt_checker (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  input wire logic [15:0] REG_ADDRESS,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic REG_DONE,
  input wire logic SPI_ACTIVE,
  input wire logic [15:0] REACTIVE_NOLOAD_THRESHOLD,
  input wire logic [15:0] APPARENT_NOLOAD_THRESHOLD,
  input wire logic [7:0] SECOND_CONFIGURATION,
  input wire logic [7:0] ACTIVE_ENERGY_THRESHOLD,
  input wire logic [7:0] REACTIVE_ENERGY_THRESHOLD,
  input wire logic [7:0] APPARENT_ENERGY_THRESHOLD,
  input wire logic SELECT_OR_STREAM_ACTIVE_PIN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held;
  logic next_held;
  logic wt;
  // strobe level seen at the previous edge
  always_comb next_held = REG_WRITE | REG_READ;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) held <= 1'b0;
    else held <= next_held;
  end
  // a write taken at this edge
  assign wt = REG_WRITE && !held;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  a_reactive_noload: assert property (
    wt && REG_ADDRESS == 16'hE909 |=>
    REACTIVE_NOLOAD_THRESHOLD == $past(REG_WDATA[15:0])) else $error("rnl");
  a_apparent_noload: assert property (
    wt && REG_ADDRESS == 16'hE90A |=>
    APPARENT_NOLOAD_THRESHOLD == $past(REG_WDATA[15:0])) else $error("anl");
  a_active_energy: assert property (
    wt && REG_ADDRESS == 16'hEA02 |=>
    ACTIVE_ENERGY_THRESHOLD == $past(REG_WDATA[7:0])) else $error("aet");
  a_reactive_energy: assert property (
    wt && REG_ADDRESS == 16'hEA03 |=>
    REACTIVE_ENERGY_THRESHOLD == $past(REG_WDATA[7:0])) else $error("ret");
  a_apparent_energy: assert property (
    wt && REG_ADDRESS == 16'hEA04 |=>
    APPARENT_ENERGY_THRESHOLD == $past(REG_WDATA[7:0])) else $error("pet");
  a_config_write: assert property (
    wt && REG_ADDRESS == 16'hEA00 |=>
    SECOND_CONFIGURATION == $past(REG_WDATA[7:0])) else $error("cfg");
  a_peak_top_zero: assert property (
    REG_DONE && $past(REG_READ) && $past(REG_ADDRESS[15:1]) == 15'h7280
    |-> REG_RDATA[31:27] == 5'h00) else $error("peak top bits");
  a_pin_write: assert property (
    wt && REG_ADDRESS == 16'hEBFF && SPI_ACTIVE |=>
    SELECT_OR_STREAM_ACTIVE_PIN == $past(REG_WDATA[0])) else $error("pin");
  a_done_answer: assert property (
    (REG_WRITE || REG_READ) && !held |=> REG_DONE) else $error("no answer");
  a_pin_no_spi: assert property (
    wt && REG_ADDRESS == 16'hEBFF && !SPI_ACTIVE |=>
    $stable(SELECT_OR_STREAM_ACTIVE_PIN)) else $error("pin without spi");
endmodule
bind mrt_tail_bank mrt_checker chk_u (.*);

// *** dv/mrt_host.sv ***
// host model issuing accesses on the register port
module mrt_host (
  input wire logic clock,
  input wire logic done,
  input wire logic [31:0] rdata,
  output logic wr,
  output logic rd,
  output logic [15:0] addr,
  output logic [31:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int misses = 0;
  initial {wr, rd, addr, wdata} = '0;
  // one access held until done, then released
  task automatic xfer(input logic w, input logic [15:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    q = '0;
    // reserved ranges are left unwritten
    if (w && a inside {[16'hE90B:16'hE9FD], [16'hEA05:16'hEBFE]}) return;
    @(negedge clock);
    {wr, rd, addr, wdata} = {w, !w, a, d};
    do @(posedge clock); while (done !== 1'b1 && ++n < 8);
    if (done !== 1'b1) misses++; // answer never came
    q = rdata;
    @(negedge clock);
    {wr, rd, addr, wdata} = {2'b00, ~a, ~d};
    @(negedge clock);
  endtask
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the metering tail register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, resetn = 0, spi = 0, cl = 0, vl = 0, wr, rd, done, pin;
  logic [15:0] addr, rn, an;
  logic [31:0] wdata, rdata, got, seed = 32'h0001_731F;
  logic [23:0] cv = '0, vv = '0;
  logic [2:0] cp = '0, vp = '0;
  logic [7:0] c2, at, rt, pt;
  logic [15:0] rw [6] = '{16'hE909, 16'hE90A, 16'hEA00, 16'hEA02,
    16'hEA03, 16'hEA04};
  logic [31:0] mdl [int];
  int fail_count = 0, checks = 0, cyc = 0;
  mrt_host host_u (.clock, .done, .rdata, .wr, .rd, .addr, .wdata);
  mrt_tail_bank dut_u (.CLOCK(clock), .RESETN(resetn), .REG_WRITE(wr),
    .REG_READ(rd), .REG_ADDRESS(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_DONE(done), .SPI_ACTIVE(spi), .CURRENT_PEAK_LOAD(cl),
    .CURRENT_PEAK_VALUE(cv), .CURRENT_PEAK_SOURCE_PHASE(cp),
    .VOLTAGE_PEAK_LOAD(vl), .VOLTAGE_PEAK_VALUE(vv),
    .VOLTAGE_PEAK_SOURCE_PHASE(vp), .REACTIVE_NOLOAD_THRESHOLD(rn),
    .APPARENT_NOLOAD_THRESHOLD(an), .SECOND_CONFIGURATION(c2),
    .ACTIVE_ENERGY_THRESHOLD(at), .REACTIVE_ENERGY_THRESHOLD(rt),
    .APPARENT_ENERGY_THRESHOLD(pt), .SELECT_OR_STREAM_ACTIVE_PIN(pin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int wid(input logic [15:0] a);
    if (a inside {16'hE909, 16'hE90A, 16'hE9FE, 16'hE9FF}) return 16;
    return (a[15:1] == 15'h7280) ? 32 : 8;
  endfunction
  task automatic check(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one access through the host, mirrored in the model
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [31:0] d);
    logic [31:0] e, m;
    m = (32'h0000_0001 << wid(a)) - 32'h0000_0001;
    e = mdl.exists(a) ? mdl[a] : '0;
    host_u.xfer(w, a, d, got);
    if (!w) check(got, e);
    if (!mdl.exists(a)) return;
    if (w && a inside {rw}) mdl[a] = d & m;
    if (w && a == 16'hEBFF && spi) mdl[a] = {31'h0000_0000, d[0]};
    if (wid(a) == 16) mdl[16'hE9FF] = w ? d & m : e;
    mdl[16'hE9FE] = a;
    mdl[16'hEA01] = {31'h0000_0000, w};
  endtask
  // load both peak captures with one source phase
  task automatic peak(input logic [23:0] v, input logic [2:0] p);
    @(negedge clock);
    {cl, vl, cv, vv, cp, vp} = {2'b11, v, ~v, p, p};
    mdl[16'hE500] = {5'h00, p, v};
    mdl[16'hE501] = {5'h00, p, ~v};
    @(negedge clock);
    {cl, vl} = 2'b00;
  endtask
  initial forever #5 clock = ~clock;
  // cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    foreach (rw[i]) mdl[rw[i]] = (i > 2) ? 32'h0000_0003 : '0;
    for (int a = 16'hE9FE; a < 16'hEA02; a++) mdl[a] = '0;
    mdl[16'hE500] = '0;
    mdl[16'hE501] = '0;
    mdl[16'hEBFF] = 32'h0000_0001;
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    // reset values, then random writes and read-backs
    foreach (mdl[a]) acc(1'b0, a[15:0], '0);
    repeat (2) foreach (rw[i]) begin
      seed = lfsr(seed);
      acc(1'b1, rw[i], seed);
      acc(1'b0, rw[i], '0);
    end
    check({rn, an}, {mdl[16'hE909][15:0], mdl[16'hE90A][15:0]});
    check({c2, at}, {mdl[16'hEA00][7:0], mdl[16'hEA02][7:0]});
    check({rt, pt}, {mdl[16'hEA03][7:0], mdl[16'hEA04][7:0]});
    // each source phase in turn
    for (int p = 0; p < 3; p++) begin
      seed = lfsr(seed);
      peak(seed[23:0], 3'b001 << p);
      acc(1'b0, 16'hE500, '0);
      acc(1'b0, 16'hE501, '0);
    end
    // read-only writes and an unmapped read
    acc(1'b1, 16'hE500, seed);
    acc(1'b1, 16'hEA01, seed);
    acc(1'b0, 16'hE500, '0);
    acc(1'b0, 16'hEA10, '0);
    acc(1'b0, 16'hE9FE, '0);
    acc(1'b0, 16'hEA01, '0);
    // pin control with and without the serial peripheral port
    acc(1'b1, 16'hEBFF, '0);
    acc(1'b0, 16'hEBFF, '0);
    check(pin, mdl[16'hEBFF]);
    spi = 1'b1;
    acc(1'b1, 16'hEBFF, '0);
    acc(1'b0, 16'hEBFF, '0);
    check(pin, mdl[16'hEBFF]);
    check(host_u.misses, 0);
    wrap_up;
  end
endmodule
